// file: status_defs.vh
/*
  Constants of the status reporting block: register offsets, bit
  positions and reset values. Assumes an APB master with 32-bit data.
*/
// Operation
// (R1) Hold latest fieldbus error code; clear it when the error register is read.
// (R2) Clear-status and reset commands leave the fieldbus error code alone.
// (R3) Client enables standard event bit 6 and status byte bit 5 for error requests.
// (R4) Questionable condition: checksum error bit 12, timeout bit 13, exception too.
// (R5) Questionable event sets on 0 to 1 change when positive filter enabled.
// (R6) With both filters enabled, event sets on every condition change.
// (R7) Reading questionable event register returns it and clears all bits.
// (R8) Only enabled questionable event bits feed the questionable summary.
// (R9) Event bits stay latched; no fresh request until register cleared.
// (R10) Operation condition reports only lockout and remote states; rest zero.
// (R11) Status bit 4 set while output queue holds data; cleared on read.
// (R12) New query over unread response discards it and reports query error.
// (R13) Request service when enabled status bit true and no read in progress.
// (R14) Protocol status read clears request-service bit; status query does not.
// (R15) Enable value 160 enables only standard event and questionable summaries.
// (R16) Power-on clear flag set zeroes enables and filters at power-up, else restore.
// (R17) Configuration save command does not store enables and filters.
// (R18) Flag write 0 stores current enables and filters; write 1 sets flag.
// (R19) Device clear keeps digital outputs; reset or recall 0 clears them.
// (R20) Clear-status clears event registers; queue bit only when first in line.
// (R21) Standard event enable takes 0..255; larger values raise execution error.
// (R22) Standard event query returns the register then clears it.
// (R23) Loading fieldbus error sets standard event bit 6; error read clears it.
// (R24) Event bits latch on rising source and hold until read or cleared.
// (R25) Each summary bit is OR of event bits ANDed with their enables.
// (R26) Service request enable bit 6 is ignored on write.
`ifndef STATUS_DEFS_VH
`define STATUS_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define A_STB     8'h00
`define A_SRE     8'h04
`define A_ESR     8'h08
`define A_ESE     8'h0C
`define A_QCOND   8'h10
`define A_QEVT    8'h14
`define A_QENA    8'h18
`define A_QPTR    8'h1C
`define A_QNTR    8'h20
`define A_OCOND   8'h24
`define A_OEVT    8'h28
`define A_OENA    8'h2C
`define A_OPTR    8'h30
`define A_ONTR    8'h34
`define A_FERR    8'h38
`define A_CMD     8'h3C
`define A_RDSTB   8'h40
`define A_PSC     8'h44
`define A_OUTQ    8'h48
`define A_DOUT    8'h4C
// ---------------------------------------------------------------
// bit positions
// ---------------------------------------------------------------
`define Q_EXC     11
`define Q_CRC     12
`define Q_TMO     13
`define O_LLO     0
`define O_REM     1
`define S_OPER    3
`define S_MAV     4
`define S_ESB     5
`define S_RQS     6
`define S_QUES    7
`define E_PON     7
`define E_FBERR   6
`define E_CMD     5
`define E_EXE     4
`define E_FLASH   3
`define E_QRY     2
`define E_EDR     1
`define C_CLS     0
`define C_RST     1
`define C_RCL0    2
`define C_SAV     3
`define C_FIRST   4
`define BYTE_MAX  32'h000000FF
`define SRE_MASK  8'hBF
`define PSC_RST   1'b1
`endif

// file: status_srq.v
/*
  Status reporting and service request block: event, enable and
  filter registers, status byte, output queue flag, fieldbus error
  code and power-on save of settings, reached over APB.
  Assumes synchronous inputs; event inputs are one-cycle pulses;
  fresetn clears the power-on store only (factory default).
*/
`timescale 1ns/1ps
`include "status_defs.vh"
module status_srq #(
  parameter EW = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          fresetn,
  input  wire          ce,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          fb_crc_err,
  input  wire          fb_exc_err,
  input  wire          fb_timeout,
  input  wire          fb_err_load,
  input  wire [EW-1:0] fb_err_code,
  input  wire          local_lockout,
  input  wire          remote_state,
  input  wire          ev_cmd_err,
  input  wire          ev_flash_err,
  input  wire          ev_edr,
  input  wire          read_busy,
  input  wire          dev_clear,
  output reg           srq,
  output reg  [7:0]    dout
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [7:0]    sre_r, ese_r, esr_r;
  reg  [15:0]   qevt_r, qena_r, qptr_r, qntr_r, qprev_r;
  reg  [15:0]   oevt_r, oena_r, optr_r, ontr_r, oprev_r;
  reg  [EW-1:0] ferr_r;
  reg           mav_r, rqs_r, armed_r, pon_r, boot_r;
  reg  [31:0]   outq_r;
  // power-on store, only cleared by the factory reset
  reg           psc_r;
  reg  [7:0]    sv_sre_r, sv_ese_r;
  reg  [15:0]   sv_qena_r, sv_qptr_r, sv_qntr_r;
  reg  [15:0]   sv_oena_r, sv_optr_r, sv_ontr_r;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // filtered transitions: rise via ptr, fall via ntr
  function [15:0] edge_set;
    input [15:0] cur;
    input [15:0] prv;
    input [15:0] ptr;
    input [15:0] ntr;
    begin
      edge_set = (ptr & cur & ~prv) | (ntr & ~cur & prv); // R5 R6
    end
  endfunction

  function summ;
    input [15:0] evt;
    input [15:0] ena;
    begin
      summ = |(evt & ena); // R25
    end
  endfunction

  // ---------------------------------------------------------------
  // condition registers and summaries
  // ---------------------------------------------------------------
  wire [15:0] qcond;
  wire [15:0] ocond;
  wire        ques_sum, oper_sum, esb_sum, mss;
  wire [7:0]  stb;
  assign qcond = ({15'h0000, fb_crc_err} << `Q_CRC)
               | ({15'h0000, fb_timeout} << `Q_TMO)
               | ({15'h0000, fb_exc_err} << `Q_EXC); // R4
  assign ocond = ({15'h0000, local_lockout} << `O_LLO)
               | ({15'h0000, remote_state} << `O_REM); // R10
  assign ques_sum = summ(qevt_r, qena_r); // R8
  assign oper_sum = summ(oevt_r, oena_r);
  assign esb_sum  = summ({8'h00, esr_r}, {8'h00, ese_r});
  // bit 6 is filled per reader: summary for query, rqs for poll
  assign stb = ({7'h00, oper_sum} << `S_OPER)
             | ({7'h00, mav_r} << `S_MAV) // R11
             | ({7'h00, esb_sum} << `S_ESB)
             | ({7'h00, ques_sum} << `S_QUES);
  assign mss = |(stb & sre_r & `SRE_MASK); // R13

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable & ~pready;
  wire acc   = psel & penable & pready;
  wire wr    = acc & pwrite & ce;
  wire rd    = acc & ~pwrite & ce;
  reg  [31:0] rdata;
  reg         hit;

  // read mux; evaluated in the setup cycle and registered
  always @* begin
    hit   = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      `A_STB:   rdata = {24'h0, stb | ({7'h00, mss} << `S_RQS)}; // R14
      `A_RDSTB: rdata = {24'h0, stb | ({7'h00, rqs_r} << `S_RQS)};
      `A_SRE:   rdata = {24'h0, sre_r & `SRE_MASK};
      `A_ESR:   rdata = {24'h0, esr_r};
      `A_ESE:   rdata = {24'h0, ese_r};
      `A_QCOND: rdata = {16'h0, qcond};
      `A_QEVT:  rdata = {16'h0, qevt_r};
      `A_QENA:  rdata = {16'h0, qena_r};
      `A_QPTR:  rdata = {16'h0, qptr_r};
      `A_QNTR:  rdata = {16'h0, qntr_r};
      `A_OCOND: rdata = {16'h0, ocond};
      `A_OEVT:  rdata = {16'h0, oevt_r};
      `A_OENA:  rdata = {16'h0, oena_r};
      `A_OPTR:  rdata = {16'h0, optr_r};
      `A_ONTR:  rdata = {16'h0, ontr_r};
      `A_FERR:  rdata = {{(32-EW){1'b0}}, ferr_r};
      `A_CMD:   rdata = 32'h00000000;
      `A_PSC:   rdata = {31'h0, psc_r};
      `A_OUTQ:  rdata = outq_r;
      `A_DOUT:  rdata = {24'h0, dout};
      default:  hit = 1'b0;
    endcase
  end

  // one wait-free access phase; unmapped answers with pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= setup;
      if (setup) begin
        pslverr <= ~hit;
        prdata  <= pwrite ? 32'h00000000 : rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // command strobes
  // ---------------------------------------------------------------
  wire w_cmd   = wr & (paddr == `A_CMD);
  wire cls     = w_cmd & pwdata[`C_CLS];
  wire cls_1st = cls & pwdata[`C_FIRST];
  wire rst_cmd = w_cmd & pwdata[`C_RST];
  wire rcl0    = w_cmd & pwdata[`C_RCL0];
  // the save command touches no enable or filter value
  wire sav     = w_cmd & pwdata[`C_SAV]; // R17
  wire big     = pwdata > `BYTE_MAX;
  wire w_ese   = wr & (paddr == `A_ESE);
  wire w_sre   = wr & (paddr == `A_SRE);
  wire w_q     = wr & (paddr == `A_OUTQ);
  wire r_q     = rd & (paddr == `A_OUTQ);
  wire r_ferr  = rd & (paddr == `A_FERR);
  wire w_psc   = wr & (paddr == `A_PSC);

  // ---------------------------------------------------------------
  // standard event register
  // ---------------------------------------------------------------
  reg [7:0] esr_set;
  always @* begin
    esr_set = 8'h00;
    esr_set[`E_PON]   = pon_r;
    esr_set[`E_FBERR] = fb_err_load; // R23
    esr_set[`E_CMD]   = ev_cmd_err;
    esr_set[`E_EXE]   = (w_ese | w_sre) & big; // R21
    esr_set[`E_FLASH] = ev_flash_err;
    esr_set[`E_QRY]   = (w_q & mav_r) | (r_q & ~mav_r); // R12
    esr_set[`E_EDR]   = ev_edr;
  end

  // clears never beat a same-cycle set
  reg [7:0] esr_clr;
  always @* begin
    esr_clr = 8'h00;
    if (cls || (rd && paddr == `A_ESR))
      esr_clr = 8'hFF; // R20 R22
    if (r_ferr)
      esr_clr[`E_FBERR] = 1'b1; // R23
  end

  // ---------------------------------------------------------------
  // event, enable and error state
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sre_r   <= 8'h00;
      ese_r   <= 8'h00;
      esr_r   <= 8'h00;
      qevt_r  <= 16'h0000;
      qena_r  <= 16'h0000;
      qptr_r  <= 16'h0000;
      qntr_r  <= 16'h0000;
      qprev_r <= 16'h0000;
      oevt_r  <= 16'h0000;
      oena_r  <= 16'h0000;
      optr_r  <= 16'h0000;
      ontr_r  <= 16'h0000;
      oprev_r <= 16'h0000;
      ferr_r  <= {EW{1'b0}};
      mav_r   <= 1'b0;
      outq_r  <= 32'h00000000;
      pon_r   <= 1'b1;
      boot_r  <= 1'b1;
      dout    <= 8'h00;
    end else if (ce) begin
      pon_r   <= 1'b0;
      boot_r  <= 1'b0;
      qprev_r <= qcond;
      oprev_r <= ocond;
      esr_r   <= (esr_r & ~esr_clr) | esr_set; // R24 R9
      // questionable event: latched until read or clear-status
      qevt_r <= (qevt_r & ~{16{cls | (rd & (paddr == `A_QEVT))}})
              | edge_set(qcond, qprev_r, qptr_r, qntr_r); // R7 R9
      oevt_r <= (oevt_r & ~{16{cls | (rd & (paddr == `A_OEVT))}})
              | edge_set(ocond, oprev_r, optr_r, ontr_r);
      // fieldbus error code: only its own read clears it
      if (fb_err_load)
        ferr_r <= fb_err_code; // R1
      else if (r_ferr)
        ferr_r <= {EW{1'b0}}; // R1 R2
      // output queue: a new response replaces an unread one
      if (w_q) begin
        outq_r <= pwdata; // R12
        mav_r  <= 1'b1; // R11
      end else if (r_q || cls_1st || dev_clear) begin
        mav_r  <= 1'b0; // R11 R20
      end
      // power-up restore of enables and filters
      if (boot_r) begin
        sre_r  <= psc_r ? 8'h00 : sv_sre_r; // R16
        ese_r  <= psc_r ? 8'h00 : sv_ese_r;
        qena_r <= psc_r ? 16'h0000 : sv_qena_r;
        qptr_r <= psc_r ? 16'h0000 : sv_qptr_r;
        qntr_r <= psc_r ? 16'h0000 : sv_qntr_r;
        oena_r <= psc_r ? 16'h0000 : sv_oena_r;
        optr_r <= psc_r ? 16'h0000 : sv_optr_r;
        ontr_r <= psc_r ? 16'h0000 : sv_ontr_r;
      end else if (wr) begin
        case (paddr)
          `A_SRE:  if (!big) sre_r <= pwdata[7:0] & `SRE_MASK; // R26 R15
          `A_ESE:  if (!big) ese_r <= pwdata[7:0]; // R21
          `A_QENA: qena_r <= pwdata[15:0];
          `A_QPTR: qptr_r <= pwdata[15:0];
          `A_QNTR: qntr_r <= pwdata[15:0];
          `A_OENA: oena_r <= pwdata[15:0];
          `A_OPTR: optr_r <= pwdata[15:0];
          `A_ONTR: ontr_r <= pwdata[15:0];
          `A_DOUT: dout   <= pwdata[7:0];
          default: ;
        endcase
      end
      // device clear leaves the outputs; reset and recall 0 drop them
      if (rst_cmd || rcl0)
        dout <= 8'h00; // R19
    end
  end

  // ---------------------------------------------------------------
  // service request
  // ---------------------------------------------------------------
  // rqs rises once per rise of the summary; a read in progress defers it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rqs_r   <= 1'b0;
      armed_r <= 1'b1;
      srq     <= 1'b0;
    end else if (ce) begin
      srq <= 1'b0;
      if (mss && armed_r && !read_busy) begin
        rqs_r   <= 1'b1; // R13 R9
        armed_r <= 1'b0;
        srq     <= 1'b1; // R13
      end else if (rd && paddr == `A_RDSTB) begin
        rqs_r   <= 1'b0; // R14
      end
      if (!mss && !rqs_r)
        armed_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // power-on store
  // ---------------------------------------------------------------
  // writing 0 snapshots the live settings; writing 1 only sets the flag
  always @(posedge pclk or negedge fresetn) begin
    if (!fresetn) begin
      psc_r     <= `PSC_RST;
      sv_sre_r  <= 8'h00;
      sv_ese_r  <= 8'h00;
      sv_qena_r <= 16'h0000;
      sv_qptr_r <= 16'h0000;
      sv_qntr_r <= 16'h0000;
      sv_oena_r <= 16'h0000;
      sv_optr_r <= 16'h0000;
      sv_ontr_r <= 16'h0000;
    end else if (ce && w_psc && !sav) begin
      psc_r <= pwdata[0]; // R18
      if (!pwdata[0]) begin
        sv_sre_r  <= sre_r; // R18
        sv_ese_r  <= ese_r;
        sv_qena_r <= qena_r;
        sv_qptr_r <= qptr_r;
        sv_qntr_r <= qntr_r;
        sv_oena_r <= oena_r;
        sv_optr_r <= optr_r;
        sv_ontr_r <= ontr_r;
      end
    end
  end

endmodule // status_srq

// file: status_chk_assertions.sv
/*
  Checker of the status block ports: APB answer, narrow reads, srq.
  Assumes it is bound to status_srq and that ce gates every state change.
*/
`timescale 1ns/1ps
`include "status_defs.vh"
module status_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        read_busy,
  input wire        dev_clear,
  input wire        srq,
  input wire [7:0]  dout
);
  // ----------------------------
  // properties
  // ----------------------------
  wire setup;
  wire rd_setup;
  // read data is taken in the setup cycle, so key on the setup decode
  assign setup    = psel && !penable && ce;
  assign rd_setup = setup && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (setup |=> pready)
    else $error("pready late");
  ready_once_a: assert property (pready && ce |=> !pready)
    else $error("pready held");
  unmapped_err_a: assert property (setup && paddr > 8'h4C |=> pslverr)
    else $error("no slverr");
  sre_bit6_a: assert property (rd_setup && paddr == `A_SRE |=> !prdata[6])
    else $error("sre bit6 set");
  oper_zero_a: assert property (rd_setup && paddr == `A_OCOND |=> prdata[31:2] == 30'h0)
    else $error("oper extra bits");
  srq_pulse_a: assert property (srq |=> !srq)
    else $error("srq long");
  busy_hold_a: assert property (read_busy [*4] |-> !srq)
    else $error("srq while busy");
  dclr_dout_a: assert property (dev_clear && !psel |=> $stable(dout))
    else $error("dout moved");
endmodule // status_chk
bind status_srq status_chk chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .read_busy(read_busy), .dev_clear(dev_clear),
  .srq(srq), .dout(dout)
);

// file: client_model.sv
/*
  Remote client model: an APB master issuing status commands.
  Assumes one clock and a slave that answers with pready.
*/
`timescale 1ns/1ps
`include "status_defs.vh"
module client_model (
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  // ----------------------------
  // bus cycle
  // ----------------------------
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // one transfer; released lines show the inverse so stale data is not trusted
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no own limit: only the bench watchdog ends a wait for pready
      @(posedge pclk);
      while (!pready) begin
        @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
    end
  endtask
  // fieldbus error loads reach srq through ESR bit 6 and status bit 5
  task arm_fb_srq;
    reg [31:0] r;
    reg        e;
    begin
      xfer(1'b1, `A_ESE, 32'h40, r, e);
      xfer(1'b1, `A_SRE, 32'h20, r, e);
    end
  endtask
endmodule // client_model

// file: status_srq_bench.sv
/*
  Self-checking bench of status_srq, using the client model for APB.
  Assumes status_defs.vh and the bound checker.
*/
`timescale 1ns/1ps
`include "status_defs.vh"
`define CK(nm, ex, got) begin \
  checks = checks + 1; \
  if ((got) !== (ex)) begin \
    failures = failures + 1; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end \
end
module status_srq_bench;
  reg         pclk;
  reg         presetn;
  reg         fresetn;
  reg         read_busy;
  reg  [2:0]  lv;
  reg  [1:0]  ol;
  reg  [4:0]  pl;
  reg  [15:0] code;
  reg  [31:0] rdv;
  reg         err;
  integer     failures;
  integer     checks;
  wire        psel, penable, pwrite, pready, pslverr, srq;
  wire [7:0]  paddr;
  wire [7:0]  dout;
  wire [31:0] pwdata;
  wire [31:0] prdata;
  status_srq #(.EW(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .fresetn(fresetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fb_crc_err(lv[0]), .fb_exc_err(lv[1]), .fb_timeout(lv[2]),
    .fb_err_load(pl[3]), .fb_err_code(code), .local_lockout(ol[0]),
    .remote_state(ol[1]), .ev_cmd_err(pl[0]), .ev_flash_err(pl[1]),
    .ev_edr(pl[2]), .read_busy(read_busy), .dev_clear(pl[4]),
    .srq(srq), .dout(dout));
  client_model cli_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ----------------------------
  // helpers
  // ----------------------------
  always #50 pclk = ~pclk;
  task rc(input [7:0] a, input [31:0] m, input [31:0] ex);
    begin
      cli_u.xfer(1'b0, a, 32'h0, rdv, err);
      `CK($sformatf("reg %h", a), ex, rdv & m)
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    cli_u.xfer(1'b1, a, d, rdv, err);
  endtask
  // srq is a one-cycle pulse, so look at every cycle of the window
  task sq(input ex);
    reg     s;
    integer i;
    begin
      s = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge pclk);
        s = s | srq;
      end
      `CK("srq", ex, s)
      @(posedge pclk);
    end
  endtask
  task pulse(input [4:0] m);
    begin
      pl <= m;
      @(posedge pclk);
      pl <= 5'h00;
    end
  endtask
  task prst;
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ----------------------------
  // scenarios
  // ----------------------------
  // power-up with flag set; also a refused address
  task t_por;
    begin
      rc(`A_ESR, 32'h80, 32'h80);
      rc(`A_QENA, 32'hFFFF, 32'h0);
      rc(`A_PSC, 32'h1, 32'h1);
      cli_u.xfer(1'b0, 8'h80, 32'h0, rdv, err);
      `CK("slverr", 1'b1, err)
    end
  endtask
  // bit 13 on both edges, bit 12 rising only and enabled, bit 11 filtered
  task t_ques;
    begin
      wr(`A_QPTR, 32'h3000);
      wr(`A_QNTR, 32'h2000);
      wr(`A_QENA, 32'h1000);
      wr(`A_OPTR, 32'h1);
      wr(`A_OENA, 32'h1);
      lv <= 3'b111;
      ol <= 2'b11;
      repeat (2) @(posedge pclk);
      rc(`A_QCOND, 32'hFFFF, 32'h3800);
      rc(`A_OCOND, 32'hFFFFFFFF, 32'h3);
      rc(`A_STB, 32'h80, 32'h80);
      rc(`A_STB, 32'h08, 32'h08);
      rc(`A_OEVT, 32'hFFFF, 32'h1);
      rc(`A_QEVT, 32'hFFFF, 32'h3000);
      rc(`A_QEVT, 32'hFFFF, 32'h0);
      lv <= 3'b011;
      repeat (2) @(posedge pclk);
      rc(`A_STB, 32'h80, 32'h0);
      rc(`A_QEVT, 32'hFFFF, 32'h2000);
      lv <= 3'b000;
      ol <= 2'b00;
      repeat (2) @(posedge pclk);
      rc(`A_QEVT, 32'hFFFF, 32'h0);
    end
  endtask
  // fieldbus error code, its event bit and what clears them
  task t_ferr;
    begin
      cli_u.arm_fb_srq;
      code <= 16'h0005;
      pulse(5'h08);
      sq(1'b1);
      rc(`A_RDSTB, 32'h40, 32'h40);
      pulse(5'h08);
      sq(1'b0);
      wr(`A_CMD, 32'h3);
      rc(`A_FERR, 32'hFFFF, 32'h5);
      rc(`A_FERR, 32'hFFFF, 32'h0);
      code <= 16'h0009;
      pulse(5'h08);
      rc(`A_FERR, 32'hFFFF, 32'h9);
      rc(`A_ESR, 32'h40, 32'h0);
      rc(`A_RDSTB, 32'h40, 32'h40);
    end
  endtask
  // request gating, status reads and the output queue
  task t_stb;
    begin
      wr(`A_SRE, 32'hFF);
      rc(`A_SRE, 32'hFF, 32'hBF);
      wr(`A_SRE, 32'hA0);
      wr(`A_ESE, 32'h20);
      read_busy <= 1'b1;
      pulse(5'h01);
      sq(1'b0);
      read_busy <= 1'b0;
      sq(1'b1);
      rc(`A_STB, 32'h40, 32'h40);
      rc(`A_RDSTB, 32'h40, 32'h40);
      rc(`A_RDSTB, 32'h40, 32'h0);
      rc(`A_ESR, 32'hFF, 32'h20);
      wr(`A_OUTQ, 32'h1);
      sq(1'b0);
      rc(`A_STB, 32'h10, 32'h10);
      wr(`A_OUTQ, 32'h2);
      rc(`A_ESR, 32'h04, 32'h04);
      rc(`A_OUTQ, 32'hFFFFFFFF, 32'h2);
      rc(`A_STB, 32'h10, 32'h0);
      wr(`A_OUTQ, 32'h3);
      wr(`A_CMD, 32'h1);
      rc(`A_STB, 32'h10, 32'h10);
      wr(`A_CMD, 32'h11);
      rc(`A_STB, 32'h10, 32'h0);
    end
  endtask
  // enable range and standard event query
  task t_ese;
    begin
      wr(`A_ESE, 32'h100);
      rc(`A_ESE, 32'hFFFFFFFF, 32'h20);
      pulse(5'h06);
      rc(`A_ESR, 32'hFF, 32'h1A);
      rc(`A_ESR, 32'hFF, 32'h0);
      wr(`A_ESE, 32'hFF);
      rc(`A_ESE, 32'hFFFFFFFF, 32'hFF);
    end
  endtask
  // snapshot by flag write, not by the save command
  task t_psc;
    begin
      wr(`A_QENA, 32'h1000);
      wr(`A_PSC, 32'h0);
      wr(`A_QENA, 32'h0);
      wr(`A_CMD, 32'h8);
      prst;
      rc(`A_QENA, 32'hFFFF, 32'h1000);
      wr(`A_PSC, 32'h1);
      prst;
      rc(`A_QENA, 32'hFFFF, 32'h0);
    end
  endtask
  task t_dclr;
    begin
      wr(`A_DOUT, 32'h5A);
      pulse(5'h10);
      @(negedge pclk);
      `CK("dout", 8'h5A, dout)
      wr(`A_CMD, 32'h4);
      @(negedge pclk);
      `CK("dout", 8'h00, dout)
    end
  endtask
  // main sequence; resets held two cycles
  initial begin
    pclk = 1'b0;
    failures = 0;
    checks = 0;
    presetn = 1'b0;
    fresetn = 1'b0;
    read_busy = 1'b0;
    lv = 3'b000;
    ol = 2'b00;
    pl = 5'h00;
    code = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    fresetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_por;
    t_ques;
    t_ferr;
    t_stb;
    t_ese;
    t_psc;
    t_dclr;
    finish_test;
  end
  // cut a hang short; the run needs well under 2000 cycles
  initial begin
    #(5000 * 100);
    failures = failures + 1;
    finish_test;
  end
endmodule // status_srq_bench
